// ==== src/acl_defines.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

`define ACL_LEADOFF_CONTROL_OFS      8'h00
`define ACL_AC_EXCITATION_OFS        8'h04
`define ACL_LEADOFF_ENABLE_OFS       8'h08
`define ACL_EXCITATION_CURRENT_OFS   8'h0c
`define ACL_LEADOFF_RESULT_OFS       8'h10
`define ACL_IRQ_STATUS_OFS           8'h14
`define ACL_IRQ_CLEAR_OFS            8'h18
`define ACL_IRQ_ENABLE_OFS           8'h1c
`define ACL_BLOCK_STATE_OFS          8'h20

`define ACL_CTL_AC_BIT               0
`define ACL_CTL_ANALOG_BIT           1
`define ACL_CTL_SHDN_BIT             2
`define ACL_CTL_LVL_LO               3
`define ACL_CTL_LVL_HI               4
`define ACL_DIV_PRESC_BIT            7

`define ACL_CTL_RST                  5'h00
`define ACL_ACDIV_RST                8'h00
`define ACL_ENABLE_RST               6'h00
`define ACL_CURRENT_RST              8'h00
`define ACL_IRQ_EN_RST               6'h00

`define ACL_RESP_OKAY                2'h0
`define ACL_RESP_SLVERR              2'h2

`define ACL_CLK_KHZ                  20000
`define ACL_BASE_KHZ                 50
`define ACL_TICK_CYC                 (`ACL_CLK_KHZ / `ACL_BASE_KHZ)
`define ACL_PRESC_K                  16
`define ACL_HALF_DIV                 2

`endif

// ==== src/acl_pkg.sv ====
// types shared by the lead-off control modules
package acl_pkg;

  typedef enum logic [1:0] {
    ACL_MODE_OFF,
    ACL_MODE_DC,
    ACL_MODE_ANALOG,
    ACL_MODE_DIGITAL
  } acl_mode_t;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [4:0]  ctrl;
    logic [7:0]  acdiv;
    logic [5:0]  enable;
    logic [7:0]  current;
    logic [5:0]  irq_en;
    logic [5:0]  clear;
    logic [5:0]  dc_en;
    logic [5:0]  src_en;
    logic [5:0]  snk_en;
    logic [2:0]  inj;
    logic [2:0]  pos_src;
    logic [2:0]  neg_src;
    logic [7:0]  cur_out;
    logic [1:0]  lvl_out;
  } acl_top_st_t;

  typedef struct packed {
    logic [8:0]  tick_cnt;
    logic [12:0] half_cnt;
    logic        phase;
  } acl_div_st_t;

  typedef struct packed {
    logic [5:0]  result;
    logic [5:0]  status;
  } acl_res_st_t;

endpackage

// ==== src/acl_core_if.sv ====
// signals between the control core, excitation divider and result latch
`timescale 1ns/100ps
interface acl_core_if;
  logic       run;
  logic [6:0] divisor;
  logic       prescale;
  logic       phase;
  logic       sample;
  logic [5:0] cmp_in;
  logic [5:0] clear;
  logic [5:0] irq_en;
  logic [5:0] result;
  logic [5:0] status;
  logic       irq;

  modport div (input run, divisor, prescale, output phase);
  modport res (input sample, cmp_in, clear, irq_en, output result, status, irq);
endinterface

// ==== src/acl_excite_div.sv ====
// excitation divider: base tick from clock, phase toggles each half period
`timescale 1ns/100ps
`include "acl_defines.svh"
module acl_excite_div #(
  parameter int unsigned TICK_CYC = `ACL_TICK_CYC  // clocks per base tick
) (
  input wire logic    clk,    // device clock
  input wire logic    rst_n,  // async reset, active low
  acl_core_if.div     dv      // divider config and phase
);
  import acl_pkg::*;

  acl_div_st_t st_ff;
  acl_div_st_t nxt_st;
  logic [12:0] half_lim;

  always_comb begin
    half_lim = 13'((13'(dv.divisor) + 13'h1) * (dv.prescale ? 13'(`ACL_PRESC_K) : 13'h1)
                   * 13'(`ACL_HALF_DIV));
    nxt_st = st_ff;
    if (!dv.run) begin
      nxt_st = '0;
    end else if (st_ff.tick_cnt >= 9'(TICK_CYC - 1)) begin
      nxt_st.tick_cnt = '0;
      if (st_ff.half_cnt >= half_lim - 13'h1) begin
        nxt_st.half_cnt = '0;
        nxt_st.phase = ~st_ff.phase;
      end else begin
        nxt_st.half_cnt = st_ff.half_cnt + 13'h1;
      end
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 9'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dv.phase = st_ff.phase;

  // cycles since last toggle, valid only while config stayed put
  logic [20:0] cyc_ff;
  logic [12:0] lim_ff;
  logic        clean_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff   <= '0;
      lim_ff   <= '0;
      clean_ff <= 1'b0;
    end else begin
      lim_ff   <= half_lim;
      cyc_ff   <= (!dv.run || nxt_st.phase != st_ff.phase) ? 21'h0 : cyc_ff + 21'h1;
      clean_ff <= (!dv.run || nxt_st.phase != st_ff.phase) ? 1'b1 :
                  (clean_ff && lim_ff == half_lim);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_half_period: assert property (
    ($changed(st_ff.phase) && $past(dv.run) && $past(clean_ff) && lim_ff == $past(lim_ff))
    |-> ($past(cyc_ff) == 21'(TICK_CYC * 32'($past(lim_ff)) - 1)))
    else $error("half period length wrong");
  chk_max_rate: assert property (
    ($changed(st_ff.phase) && $past(dv.run) && $past(clean_ff))
    |-> ($past(cyc_ff) >= 21'(TICK_CYC * 2 - 1)))
    else $error("excitation faster than maximum");
  chk_idle_reset: assert property (
    !dv.run |=> (st_ff == '0))
    else $error("divider not held while idle");
endmodule

// ==== src/acl_result_latch.sv ====
// comparator result latch with sticky lead-off events and interrupt
`timescale 1ns/100ps
module acl_result_latch (
  input wire logic    clk,    // device clock
  input wire logic    rst_n,  // async reset, active low
  acl_core_if.res     rs      // comparator in, result and status out
);
  import acl_pkg::*;

  acl_res_st_t st_ff;
  acl_res_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.result = rs.sample ? rs.cmp_in : 6'h00;
    // new lead-off event wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~rs.clear) | (nxt_st.result & ~st_ff.result);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rs.result = st_ff.result;
  assign rs.status = st_ff.status;
  assign rs.irq    = |(st_ff.status & rs.irq_en);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_result_follow: assert property (
    rs.sample |=> (rs.result == $past(rs.cmp_in)))
    else $error("result does not follow comparator");
  chk_no_sample: assert property (
    !rs.sample |=> (rs.result == 6'h00))
    else $error("result set without detection");
  chk_sticky_set: assert property (
    ((rs.result & ~$past(rs.result)) != 6'h00) |-> ((rs.status & rs.result & ~$past(rs.result))
    == (rs.result & ~$past(rs.result))))
    else $error("event lost from status");
endmodule

// ==== src/acl_leadoff_ctrl.sv ====
// AC lead-off control: register slave, mode decode and excitation routing
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "acl_defines.svh"

// Contract
// - analog AC mode needs both select bits set
// - AC set, analog clear selects digital AC
// - frequency is 50 kHz over 4K(divisor+1)
// - divisor 0, prescale 0 gives 12.5 kHz maximum
// - analog enables drive complementary sink/source switches
// - AC current amplitude follows shared current code
// - 2-bit field picks one of four thresholds
// - comparator outputs readable as result bits; the code reads zero in digital AC mode and shutdown
// - digital enable bits 2:0 pick channels 3:1
// - digital enable bits 5:3 invert channel phase
// - positive input gets current, negative the opposite
// - digital current magnitude uses shared current code
// - AC select clear means DC mode, no AC
// - 8-bit current code steps linearly by 8 nA
// - shutdown disables excitation and detection entirely
module acl_leadoff_ctrl #(
  parameter int unsigned TICK_CYC = `ACL_TICK_CYC  // clocks per 50 kHz tick
) (
  input  wire logic        clk,                      // 20 MHz device clock
  input  wire logic        rst_n,                    // async reset, active low
  input  wire logic        s_axil_awvalid,           // write address valid
  output logic             s_axil_awready,           // write address ready
  input  wire logic [7:0]  s_axil_awaddr,            // write byte address
  input  wire logic        s_axil_wvalid,            // write data valid
  output logic             s_axil_wready,            // write data ready
  input  wire logic [31:0] s_axil_wdata,             // write data
  input  wire logic [3:0]  s_axil_wstrb,             // write byte strobes
  output logic             s_axil_bvalid,            // write response valid
  input  wire logic        s_axil_bready,            // write response ready
  output logic [1:0]       s_axil_bresp,             // write response code
  input  wire logic        s_axil_arvalid,           // read address valid
  output logic             s_axil_arready,           // read address ready
  input  wire logic [7:0]  s_axil_araddr,            // read byte address
  output logic             s_axil_rvalid,            // read data valid
  input  wire logic        s_axil_rready,            // read data ready
  output logic [31:0]      s_axil_rdata,             // read data
  output logic [1:0]       s_axil_rresp,             // read response code
  input  wire logic [5:0]  leadoff_comparator,       // per-pin comparator outputs
  output logic [5:0]       pin_dc_en,                // dc current switch per pin
  output logic [5:0]       pin_source_en,            // ac source switch per pin
  output logic [5:0]       pin_sink_en,              // ac sink switch per pin
  output logic [2:0]       ch_inject_en,             // digital ac channel select
  output logic [2:0]       ch_pos_source,            // positive input sourcing
  output logic [2:0]       ch_neg_source,            // negative input sourcing
  output logic [7:0]       excitation_current_code,  // current dac code
  output logic [1:0]       ac_threshold_level,       // ac comparator threshold
  output logic             irq                       // level interrupt
);
  import acl_pkg::*;

  acl_top_st_t st_ff;
  acl_top_st_t nxt_st;
  acl_mode_t   mode;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        have_aw;
  logic        have_w;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  logic [2:0]  ch_phase;

  acl_core_if cif ();

  acl_excite_div #(
    .TICK_CYC (TICK_CYC)
  ) u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .dv    (cif.div)
  );

  acl_result_latch u_res (
    .clk   (clk),
    .rst_n (rst_n),
    .rs    (cif.res)
  );

  // mode decode, shutdown first
  always_comb begin
    if (st_ff.ctrl[`ACL_CTL_SHDN_BIT]) begin
      mode = ACL_MODE_OFF;
    end else if (!st_ff.ctrl[`ACL_CTL_AC_BIT]) begin
      mode = ACL_MODE_DC;
    end else if (st_ff.ctrl[`ACL_CTL_ANALOG_BIT]) begin
      mode = ACL_MODE_ANALOG;
    end else begin
      mode = ACL_MODE_DIGITAL;
    end
  end

  assign cif.run      = (mode == ACL_MODE_ANALOG) || (mode == ACL_MODE_DIGITAL);
  assign cif.divisor  = st_ff.acdiv[6:0];
  assign cif.prescale = st_ff.acdiv[`ACL_DIV_PRESC_BIT];
  assign cif.sample   = (mode == ACL_MODE_DC) || (mode == ACL_MODE_ANALOG);
  assign cif.cmp_in   = leadoff_comparator;
  assign cif.clear    = st_ff.clear;
  assign cif.irq_en   = st_ff.irq_en;

  // handshakes
  assign s_axil_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axil_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axil_arready = !st_ff.rvalid;
  assign aw_hs          = s_axil_awvalid && s_axil_awready;
  assign w_hs           = s_axil_wvalid && s_axil_wready;
  assign ar_hs          = s_axil_arvalid && s_axil_arready;
  assign have_aw        = st_ff.aw_got || aw_hs;
  assign have_w         = st_ff.w_got || w_hs;
  assign wr_addr        = st_ff.aw_got ? st_ff.awaddr : s_axil_awaddr;
  assign wr_data        = st_ff.w_got ? st_ff.wdata : s_axil_wdata;
  assign wr_strb        = st_ff.w_got ? st_ff.wstrb : s_axil_wstrb;

  // read mux
  always_comb begin
    rd_data = 32'h0;
    rd_resp = `ACL_RESP_OKAY;
    case ({s_axil_araddr[7:2], 2'h0})
      `ACL_LEADOFF_CONTROL_OFS:    rd_data[4:0] = st_ff.ctrl;
      `ACL_AC_EXCITATION_OFS:      rd_data[7:0] = st_ff.acdiv;
      `ACL_LEADOFF_ENABLE_OFS:     rd_data[5:0] = st_ff.enable;
      `ACL_EXCITATION_CURRENT_OFS: rd_data[7:0] = st_ff.current;
      `ACL_LEADOFF_RESULT_OFS:     rd_data[5:0] = cif.result;
      `ACL_IRQ_STATUS_OFS:         rd_data[5:0] = cif.status;
      `ACL_IRQ_CLEAR_OFS:          rd_data = 32'h0;
      `ACL_IRQ_ENABLE_OFS:         rd_data[5:0] = st_ff.irq_en;
      `ACL_BLOCK_STATE_OFS:        rd_data[2:0] = {cif.phase, mode};
      default:                     rd_resp = `ACL_RESP_SLVERR;
    endcase
  end

  // per-channel phase, anti-phase where the invert bit is set
  assign ch_phase = st_ff.enable[5:3] ^ {3{cif.phase}};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clear = 6'h00;

    // write channel
    if (st_ff.bvalid && s_axil_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (have_aw && have_w && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = `ACL_RESP_OKAY;
      case ({wr_addr[7:2], 2'h0})
        `ACL_LEADOFF_CONTROL_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.ctrl = wr_data[4:0];
          end
        end
        `ACL_AC_EXCITATION_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.acdiv = wr_data[7:0];
          end
        end
        `ACL_LEADOFF_ENABLE_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.enable = wr_data[5:0];
          end
        end
        `ACL_EXCITATION_CURRENT_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.current = wr_data[7:0];
          end
        end
        `ACL_IRQ_CLEAR_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.clear = wr_data[5:0];
          end
        end
        `ACL_IRQ_ENABLE_OFS: begin
          if (wr_strb[0]) begin
            nxt_st.irq_en = wr_data[5:0];
          end
        end
        `ACL_LEADOFF_RESULT_OFS, `ACL_IRQ_STATUS_OFS, `ACL_BLOCK_STATE_OFS: begin
          nxt_st.bresp = `ACL_RESP_OKAY;
        end
        default: begin
          nxt_st.bresp = `ACL_RESP_SLVERR;
        end
      endcase
    end else begin
      if (aw_hs) begin
        nxt_st.aw_got = 1'b1;
        nxt_st.awaddr = s_axil_awaddr;
      end
      if (w_hs) begin
        nxt_st.w_got = 1'b1;
        nxt_st.wdata = s_axil_wdata;
        nxt_st.wstrb = s_axil_wstrb;
      end
    end

    // read channel
    if (st_ff.rvalid && s_axil_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_data;
      nxt_st.rresp  = rd_resp;
    end

    // excitation routing
    nxt_st.dc_en   = 6'h00;
    nxt_st.src_en  = 6'h00;
    nxt_st.snk_en  = 6'h00;
    nxt_st.inj     = 3'h0;
    nxt_st.pos_src = 3'h0;
    nxt_st.neg_src = 3'h0;
    nxt_st.cur_out = st_ff.current;
    nxt_st.lvl_out = st_ff.ctrl[`ACL_CTL_LVL_HI:`ACL_CTL_LVL_LO];
    unique case (mode)
      ACL_MODE_OFF: begin
        nxt_st.cur_out = 8'h00;
      end
      ACL_MODE_DC: begin
        nxt_st.dc_en = st_ff.enable;
      end
      ACL_MODE_ANALOG: begin
        nxt_st.src_en = st_ff.enable & {6{cif.phase}};
        nxt_st.snk_en = st_ff.enable & ~{6{cif.phase}};
      end
      ACL_MODE_DIGITAL: begin
        nxt_st.inj     = st_ff.enable[2:0];
        nxt_st.pos_src = st_ff.enable[2:0] & ch_phase;
        nxt_st.neg_src = st_ff.enable[2:0] & ~ch_phase;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= '0;
      st_ff.ctrl    <= `ACL_CTL_RST;
      st_ff.acdiv   <= `ACL_ACDIV_RST;
      st_ff.enable  <= `ACL_ENABLE_RST;
      st_ff.current <= `ACL_CURRENT_RST;
      st_ff.irq_en  <= `ACL_IRQ_EN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axil_bvalid           = st_ff.bvalid;
  assign s_axil_bresp            = st_ff.bresp;
  assign s_axil_rvalid           = st_ff.rvalid;
  assign s_axil_rdata            = st_ff.rdata;
  assign s_axil_rresp            = st_ff.rresp;
  assign pin_dc_en               = st_ff.dc_en;
  assign pin_source_en           = st_ff.src_en;
  assign pin_sink_en             = st_ff.snk_en;
  assign ch_inject_en            = st_ff.inj;
  assign ch_pos_source           = st_ff.pos_src;
  assign ch_neg_source           = st_ff.neg_src;
  assign excitation_current_code = st_ff.cur_out;
  assign ac_threshold_level      = st_ff.lvl_out;
  assign irq                     = cif.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_last;
    (aw_hs && have_w) || (w_hs && have_aw);
  endsequence

  sequence s_wr_answer;
    s_axil_bvalid && !s_axil_awready && !s_axil_wready;
  endsequence

  chk_write_answer: assert property (
    s_wr_last |=> s_wr_answer)
    else $error("write response missing");
  chk_bresp_hold: assert property (
    (s_axil_bvalid && !s_axil_bready) |=> (s_axil_bvalid && $stable(s_axil_bresp)))
    else $error("write response dropped early");
  chk_read_answer: assert property (
    ar_hs |=> (s_axil_rvalid && !s_axil_arready))
    else $error("read response missing");
  chk_rdata_hold: assert property (
    (s_axil_rvalid && !s_axil_rready) |=> (s_axil_rvalid && $stable(s_axil_rdata)))
    else $error("read data changed while waiting");
  chk_analog_only: assert property (
    ((pin_source_en | pin_sink_en) != 6'h00) |->
    $past(st_ff.ctrl[`ACL_CTL_AC_BIT] && st_ff.ctrl[`ACL_CTL_ANALOG_BIT]
          && !st_ff.ctrl[`ACL_CTL_SHDN_BIT]))
    else $error("ac switches outside analog mode");
  chk_digital_decode: assert property (
    (ch_inject_en != 3'h0) |->
    $past(st_ff.ctrl[`ACL_CTL_AC_BIT] && !st_ff.ctrl[`ACL_CTL_ANALOG_BIT]
          && !st_ff.ctrl[`ACL_CTL_SHDN_BIT]))
    else $error("channel injection outside digital mode");
  chk_analog_pair: assert property (
    (mode == ACL_MODE_ANALOG) |=>
    (pin_source_en == ($past(st_ff.enable) & {6{$past(cif.phase)}}))
    && ((pin_source_en ^ pin_sink_en) == $past(st_ff.enable)))
    else $error("analog switches not complementary");
  chk_current_code: assert property (
    $past(mode != ACL_MODE_OFF) |-> (excitation_current_code == $past(st_ff.current)))
    else $error("current code not passed through");
  chk_threshold: assert property (
    ##1 (ac_threshold_level == $past(st_ff.ctrl[`ACL_CTL_LVL_HI:`ACL_CTL_LVL_LO])))
    else $error("threshold level wrong");
  chk_channel_map: assert property (
    (mode == ACL_MODE_DIGITAL) |=> (ch_inject_en == $past(st_ff.enable[2:0])))
    else $error("channel select mapping wrong");
  chk_phase_invert: assert property (
    (mode == ACL_MODE_DIGITAL) |=>
    (ch_pos_source == ($past(st_ff.enable[2:0])
                       & ($past(st_ff.enable[5:3]) ^ {3{$past(cif.phase)}}))))
    else $error("channel phase wrong");
  chk_neg_opposite: assert property (
    (ch_pos_source ^ ch_neg_source) == ch_inject_en)
    else $error("negative input not opposite");
  chk_dc_no_ac: assert property (
    (mode == ACL_MODE_DC) |=>
    (pin_source_en == 6'h00) && (pin_sink_en == 6'h00) && (ch_inject_en == 3'h0)
    && (pin_dc_en == $past(st_ff.enable)))
    else $error("ac excitation in dc mode");
  chk_shutdown_quiet: assert property (
    (mode == ACL_MODE_OFF) [*2] |->
    (pin_dc_en == 6'h00) && (pin_source_en == 6'h00) && (ch_inject_en == 3'h0)
    && (excitation_current_code == 8'h00) && (cif.result == 6'h00))
    else $error("lead-off active during shutdown");
endmodule

// ==== sim/acl_lead_model.sv ====
// electrode and comparator model at the pin side
`timescale 1ns/100ps
module acl_lead_model (
  input  wire logic [5:0] lead_off,  // pins with an open lead
  input  wire logic [5:0] dc_en,     // dc switch per pin
  input  wire logic [5:0] src_en,    // ac source switch per pin
  input  wire logic [5:0] snk_en,    // ac sink switch per pin
  output logic [5:0]      cmp        // comparator outputs
);
  // open lead plus excitation lifts the pin over threshold
  assign cmp = lead_off & (dc_en | src_en | snk_en);
endmodule

// ==== sim/test_ac_leadoff_control.sv ====
// self-checking bench for the lead-off control block
`timescale 1ns/100ps
module test_ac_leadoff_control;
  import acl_pkg::*;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] m;
    logic [7:0] e;
    logic [1:0] rs;
  } acl_row_t;
  localparam int TCK = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_arvalid = 1'b0;
  logic        s_axil_bready = 1'b1, s_axil_rready = 1'b1;
  logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0;
  logic [3:0]  s_axil_wstrb = 4'hf;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic        s_axil_arready, s_axil_rvalid, irq;
  logic [1:0]  s_axil_bresp, s_axil_rresp, ac_threshold_level;
  logic [31:0] s_axil_rdata;
  logic [5:0]  leadoff_comparator, pin_dc_en, pin_source_en, pin_sink_en;
  logic [5:0]  lead_off = 6'h00;
  logic [2:0]  ch_inject_en, ch_pos_source, ch_neg_source;
  logic [7:0]  excitation_current_code;
  int          mismatches = 0;
  int          num_checks = 0;
  acl_row_t    rows [14];

  acl_leadoff_ctrl #(.TICK_CYC(TCK)) dut (.*);
  acl_lead_model model (.lead_off(lead_off), .dc_en(pin_dc_en), .src_en(pin_source_en),
                        .snk_en(pin_sink_en), .cmp(leadoff_comparator));

  always #25 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h0, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    r = s_axil_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
  endtask

  task automatic wait_src(input logic v);
    for (int i = 0; i < 2000 && pin_source_en[0] !== v; i++) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    int          n;
    rows = '{
      '{8'h00, 8'hff, 8'h00, 8'hff, 8'h1f, 2'h0},
      '{8'h04, 8'hff, 8'h04, 8'hff, 8'hff, 2'h0},
      '{8'h08, 8'hff, 8'h08, 8'hff, 8'h3f, 2'h0},
      '{8'h0c, 8'ha5, 8'h0c, 8'hff, 8'ha5, 2'h0},
      '{8'h1c, 8'hff, 8'h1c, 8'hff, 8'h3f, 2'h0},
      '{8'h18, 8'hff, 8'h18, 8'hff, 8'h00, 2'h0},
      '{8'h10, 8'hff, 8'h10, 8'hff, 8'h00, 2'h0},
      '{8'h24, 8'hff, 8'h24, 8'hff, 8'h00, 2'h2},
      '{8'h1c, 8'h00, 8'h1c, 8'hff, 8'h00, 2'h0},
      '{8'h00, 8'h00, 8'h20, 8'h03, 8'h01, 2'h0},
      '{8'h00, 8'h01, 8'h20, 8'h03, 8'h03, 2'h0},
      '{8'h00, 8'h03, 8'h20, 8'h03, 8'h02, 2'h0},
      '{8'h00, 8'h02, 8'h20, 8'h03, 8'h01, 2'h0},
      '{8'h00, 8'h07, 8'h20, 8'h03, 8'h00, 2'h0}
    };
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      rd(k == 4 ? 8'h1c : 8'(k * 4), d, r);
      chk(d, 32'h0);
    end
    chk(irq, 1'b0);
    foreach (rows[k]) begin
      wr(rows[k].wa, rows[k].wd, r);
      chk(r, rows[k].rs);
      rd(rows[k].ra, d, r);
      chk(d & rows[k].m, rows[k].e);
      chk(r, rows[k].rs);
    end
    // analog mode, pin 0 only
    wr(8'h08, 8'h01, r);
    wr(8'h0c, 8'h40, r);
    wr(8'h04, 8'h00, r);
    wr(8'h00, 8'h1b, r);
    repeat (2) @(posedge clk);
    chk(ac_threshold_level, 2'h3);
    chk(excitation_current_code, 8'h40);
    chk(pin_source_en ^ pin_sink_en, 6'h01);
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, k ? 8'h82 : 8'h00, r);
      wait_src(1'b0);
      wait_src(1'b1);
      n = 0;
      do begin
        n++;
        @(posedge clk);
      end while (pin_source_en[0]);
      chk(n, k ? TCK * 2 * 16 * 3 : TCK * 2);
    end
    // digital mode, ch1 and ch2, ch2 anti-phase, host order kept
    wr(8'h00, 8'h01, r);
    lead_off <= 6'h3f;
    wr(8'h04, 8'h00, r);
    wr(8'h08, 8'h03, r);
    wr(8'h08, 8'h13, r);
    repeat (20) begin
      @(posedge clk);
      chk(ch_inject_en, 3'h3);
      chk(ch_pos_source ^ ch_neg_source, 3'h3);
      chk(ch_pos_source[1] ^ ch_pos_source[0], 1'b1);
    end
    chk(excitation_current_code, 8'h40);
    rd(8'h10, d, r);
    chk(d, 32'h0);
    // analog with open lead on pin 0
    wr(8'h08, 8'h01, r);
    wr(8'h00, 8'h03, r);
    repeat (3) @(posedge clk);
    rd(8'h10, d, r);
    chk(d, 32'h01);
    rd(8'h14, d, r);
    chk(d, 32'h01);
    chk(irq, 1'b0);
    wr(8'h1c, 8'h01, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(8'h18, 8'h01, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // shutdown stops excitation and detection
    wr(8'h00, 8'h07, r);
    repeat (2) @(posedge clk);
    chk(excitation_current_code, 8'h00);
    chk(pin_source_en | pin_sink_en, 6'h00);
    rd(8'h10, d, r);
    chk(d, 32'h0);
    // dc mode drives only the enabled pin
    wr(8'h00, 8'h00, r);
    repeat (2) @(posedge clk);
    chk(pin_dc_en, 6'h01);
    chk(pin_source_en | pin_sink_en, 6'h00);
    // mid-run reset returns to idle dc mode with clean status
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pin_dc_en, 6'h00);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h08, d, r);
    chk(d, 32'h0);
    rd(8'h14, d, r);
    chk(d, 32'h0);
    tally_and_finish();
  end
endmodule
